// File: dv/tb.sv
// self-checking bench: drives the watchdog over classic wishbone.
// assumes shortened prescale and pulse counts; reset pin has a pull-up.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PS = 16;
    localparam int PL = 8;
    localparam logic [7:0] CA = wdg_pkg::ADR_CONTROL;
    localparam logic [7:0] SA = wdg_pkg::ADR_STATUS;
    logic mclk = 1'h0;
    logic sys_rst = 1'h1;
    logic cyc = 1'h0;
    logic stb = 1'h0;
    logic we = 1'h0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic ack;
    logic opt_hw = 1'h0;
    logic opt_hr = 1'h0;
    logic halt_req = 1'h0;
    logic halt_enter;
    logic pin_out;
    logic oe_n;
    wire logic pin = (oe_n === 1'h0) ? pin_out : 1'h1;
    int miscompares = 0;
    int checks_done = 0;
    int n;
    int m;
    logic he;
    logic [31:0] r1;
    logic [31:0] r2;
    logic [6:0] e;

    always #2 mclk = ~mclk;

    windowed_reset_watchdog #(.PRESCALE(PS), .PULSE_CYCLES(PL))
    u_windowed_reset_watchdog (
        .mclk(mclk), .sys_rst(sys_rst),
        .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
        .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .opt_hw_watchdog(opt_hw), .opt_halt_reset(opt_hr),
        .halt_req(halt_req), .halt_enter(halt_enter),
        .rst_pin_in(pin), .rst_pin_out(pin_out), .rst_pin_oe_n(oe_n)
    );

    task print_verdict;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task bus(input logic w, input logic [7:0] a, input logic [7:0] d,
             input logic [3:0] s, output logic [31:0] q);
        int k;
        @(posedge mclk);
        cyc <= 1'h1;
        stb <= 1'h1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= {24'h0, d};
        k = 0;
        do begin
            @(posedge mclk);
            k++;
        end while (ack !== 1'h1 && k < 20);
        if (ack !== 1'h1) begin
            miscompares++;
            print_verdict;
        end
        q = rdat;
        cyc <= 1'h0;
        stb <= 1'h0;
        we <= 1'h0;
    endtask

    task do_reset(input logic hw, input logic hr);
        @(posedge mclk);
        opt_hw <= hw;
        opt_hr <= hr;
        sys_rst <= 1'h1;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'h0;
    endtask

    // counts edges until the pin is pulled, up to a bound
    task wait_low(input int bound, output int k);
        k = 0;
        while (oe_n !== 1'h0 && k < bound) begin
            @(posedge mclk);
            k++;
        end
    endtask

    task pulse_len(output int k);
        k = 0;
        while (oe_n === 1'h0 && k < 100) begin
            @(posedge mclk);
            k++;
        end
    endtask

    task quiet(input int len, output int lows);
        lows = 0;
        repeat (len) begin
            @(posedge mclk);
            if (oe_n !== 1'h1) lows++;
        end
    endtask

    task halt(output logic h, output int k);
        @(posedge mclk);
        halt_req <= 1'h1;
        @(posedge mclk);
        halt_req <= 1'h0;
        h = 1'h0;
        k = 0;
        repeat (3) begin
            @(posedge mclk);
            if (halt_enter === 1'h1) h = 1'h1;
            if (oe_n === 1'h0) k++;
        end
    endtask

    initial begin
        do_reset(1'h0, 1'h1);
        bus(1'h0, CA, 8'h00, 4'h0, r1);
        chk(r1[7], 1'h0);
        // reads 80 clocks apart see five decrements
        repeat (77) @(posedge mclk);
        bus(1'h0, CA, 8'h00, 4'h0, r2);
        e = r1[6:0] - 7'h05;
        chk(r2[6:0], e);
        bus(1'h1, CA, 8'h7f, 4'h1, r1);
        quiet(1100, n);
        chk(n, 0);
        $display("test inactive done");

        bus(1'h1, CA, 8'hc5, 4'h1, r1);
        bus(1'h0, CA, 8'h00, 4'h0, r1);
        chk(r1[7:6], 2'h3);
        bus(1'h1, CA, 8'h7f, 4'h1, r1);
        bus(1'h0, CA, 8'h00, 4'h0, r1);
        chk(r1[7], 1'h1);
        m = 0;
        repeat (6) begin
            bus(1'h1, CA, 8'hc8, 4'h1, r1);
            quiet(100, n);
            m += n;
        end
        chk(m, 0);
        bus(1'h1, CA, 8'hc8, 4'h1, r1);
        // refused writes must not reach the control byte
        bus(1'h1, 8'h08, 8'h85, 4'h1, r1);
        bus(1'h1, CA, 8'h85, 4'he, r1);
        bus(1'h0, 8'h08, 8'h00, 4'h0, r1);
        chk(r1, 32'h0);
        quiet(20, n);
        chk(n, 0);
        bus(1'h1, CA, 8'hc8, 4'h1, r1);
        halt(he, n);
        chk(he, 1'h0);
        chk(n > 0, 1'h1);
        wait_low(10, n);
        pulse_len(m);
        bus(1'h0, SA, 8'h00, 4'h0, r1);
        chk(r1[6:5], 2'h3);
        chk(r1[2:0], 3'h5);
        bus(1'h1, CA, 8'hc3, 4'h1, r1);
        wait_low(200, n);
        chk(n >= 3 * PS + 1 && n <= 4 * PS + 2, 1'h1);
        pulse_len(m);
        chk(m, PL);
        repeat (4) @(posedge mclk);
        bus(1'h0, SA, 8'h00, 4'h0, r1);
        chk(r1[4], 1'h1);
        $display("test active done");

        do_reset(1'h0, 1'h0);
        bus(1'h1, CA, 8'hc5, 4'h1, r1);
        halt(he, n);
        chk(he, 1'h1);
        chk(n, 0);
        bus(1'h1, CA, 8'h85, 4'h1, r1);
        wait_low(5, n);
        chk(n < 5, 1'h1);
        repeat (2) @(posedge mclk);
        bus(1'h0, SA, 8'h00, 4'h0, r1);
        chk(r1[4:3], 2'h1);
        pulse_len(m);
        bus(1'h0, SA, 8'h00, 4'h0, r1);
        chk(r1[6:5], 2'h2);
        $display("test soft reset done");

        // hardware watchdog times out from 7fh with no write at all
        do_reset(1'h1, 1'h0);
        wait_low(1200, n);
        chk(n >= 64 * PS - 4 && n <= 64 * PS + 4, 1'h1);
        pulse_len(m);
        bus(1'h0, SA, 8'h00, 4'h0, r1);
        chk(r1[2:0], 3'h3);
        chk(r1[6:5], 2'h1);
        $display("test hardware done");

        do_reset(1'h0, 1'h1);
        halt(he, n);
        chk(he, 1'h1);
        chk(n, 0);
        bus(1'h0, CA, 8'h00, 4'h0, r1);
        chk(r1[7], 1'h0);
        chk(r1[6:0], wdg_pkg::CNT_RESET);
        bus(1'h0, SA, 8'h00, 4'h0, r1);
        chk(r1[13:8], wdg_pkg::CNT_RESET[5:0]);
        $display("test halt inactive done");
        print_verdict;
    end
endmodule

// File: rtl/wdg_ctl_if.sv
// carrier between the watchdog core, its prescaler and its pulse stretcher.
// assumes all parties run on mclk.
interface wdg_ctl_if;
    logic tick;
    logic fire;
    logic busy;

    modport timer (output tick);
    modport pulse (input fire, output busy);
    modport core (input tick, output fire, input busy);
endinterface

// File: rtl/wdg_pkg.sv
// constants, register map and enumerations of the watchdog.
// assumes mclk stands in for the internal oscillator clock.
package wdg_pkg;

    // clock and timing
    localparam int CLK_MHZ = 250;
    localparam int OSC_DIV = 16384;
    localparam int RST_PULSE_NS = 30000;
    localparam int RST_PULSE_CYC = (RST_PULSE_NS * CLK_MHZ + 999) / 1000;

    // watchdog_control layout
    localparam int CNT_W = 7;
    localparam int STEP_W = 6;
    localparam int ACT_BIT = 7;
    localparam int TOP_BIT = 6;
    localparam logic [6:0] CNT_RESET = 7'h7f;
    localparam logic [6:0] CNT_EDGE = 7'h40;

    // register offsets (byte addresses)
    localparam int ADR_W = 8;
    localparam logic [7:0] ADR_CONTROL = 8'h00;
    localparam logic [7:0] ADR_STATUS = 8'h04;

    // status register fields
    localparam int ST_ACTIVE = 0;
    localparam int ST_HW = 1;
    localparam int ST_HALT_RST = 2;
    localparam int ST_PULSE = 3;
    localparam int ST_PIN = 4;
    localparam int ST_CAUSE = 5;
    localparam int ST_STEPS = 8;

    typedef enum logic [1:0] {
        CAUSE_NONE,
        CAUSE_TIMEOUT,
        CAUSE_SOFT,
        CAUSE_HALT
    } cause_type;

endpackage

// File: rtl/wdg_prescaler.sv
// free-running prescaler giving one tick per DIV clocks.
// assumes only sys_rst may restart it; register writes never do.
module wdg_prescaler #(
    parameter int DIV = wdg_pkg::OSC_DIV
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // tick to the core
    wdg_ctl_if.timer ctl
);
    localparam int W = $clog2(DIV);
    localparam logic [W-1:0] LAST = W'(DIV - 1);

    logic [W-1:0] div_q;
    wire wrap = (div_q == LAST);

    // no write port here, so the phase survives control writes
    always_ff @(posedge mclk) begin
        if (sys_rst || wrap) begin
            div_q <= '0;
        end else begin
            div_q <= div_q + 1'b1;
        end
    end

    assign ctl.tick = wrap;

    int gap_q;
    logic seen_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            gap_q <= 0;
            seen_q <= 1'b0;
        end else begin
            gap_q <= wrap ? 0 : gap_q + 1;
            seen_q <= seen_q | wrap;
        end
    end

    a_tick_spacing: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (wrap && seen_q) |-> (gap_q == DIV - 1))
        else $error("prescaler tick spacing wrong");
endmodule

// File: rtl/wdg_reset_pulse.sv
// stretches one fire request into a low pulse on the reset pin.
// assumes fire is ignored while a pulse is already running.
module wdg_reset_pulse #(
    parameter int LEN = wdg_pkg::RST_PULSE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // request from the core
    wdg_ctl_if.pulse ctl,
    // pin enable, low while pulling the pin down
    output logic pin_oe_n
);
    typedef enum logic {PULSE_IDLE, PULSE_LOW} pulse_type;

    localparam int CW = $clog2(LEN + 1);
    localparam logic [CW-1:0] LOAD = CW'(LEN - 1);

    pulse_type state_q, state_d;
    logic [CW-1:0] left_q;
    wire last = (left_q == '0);

    always_comb begin
        state_d = state_q;
        case (state_q)
            PULSE_IDLE: if (ctl.fire) state_d = PULSE_LOW;
            PULSE_LOW: if (last) state_d = PULSE_IDLE;
            default: state_d = PULSE_IDLE;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            state_q <= PULSE_IDLE;
            left_q <= '0;
            pin_oe_n <= 1'b1;
        end else begin
            state_q <= state_d;
            left_q <= (state_q == PULSE_IDLE) ? LOAD : left_q - 1'b1;
            pin_oe_n <= (state_d != PULSE_LOW);
        end
    end

    assign ctl.busy = (state_q == PULSE_LOW);

    int run_q;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_q <= 0;
        end else begin
            run_q <= ctl.busy ? run_q + 1 : 0;
        end
    end

    a_pulse_length: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $fell(ctl.busy) |-> (run_q == LEN))
        else $error("reset pulse length wrong");
endmodule

// File: rtl/windowed_reset_watchdog.sv
// watchdog core: counter, control and status registers, wishbone slave.
// assumes mclk is the internal oscillator clock and the halt request
// and option bits come from logic on the same clock.
//
// Decided for this implementation: the register addresses and the Wishbone slave port.

module windowed_reset_watchdog #(
    parameter int PRESCALE = wdg_pkg::OSC_DIV,
    parameter int PULSE_CYCLES = wdg_pkg::RST_PULSE_CYC
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // wishbone classic slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wdg_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // option byte bits
    input wire logic opt_hw_watchdog,
    input wire logic opt_halt_reset,
    // cpu halt handshake
    input wire logic halt_req,
    output logic halt_enter,
    // open-drain reset pin
    input wire logic rst_pin_in,
    output logic rst_pin_out,
    output logic rst_pin_oe_n
);

    wdg_ctl_if ctl ();

    wdg_prescaler #(
        .DIV(PRESCALE)
    ) u_prescaler (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ctl(ctl.timer)
    );

    wdg_reset_pulse #(
        .LEN(PULSE_CYCLES)
    ) u_pulse (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .ctl(ctl.pulse),
        .pin_oe_n(rst_pin_oe_n)
    );

    // the pin is only ever pulled low
    assign rst_pin_out = 1'b0;

    // bus decode
    logic ack_q;
    logic [31:0] dat_q;

    wire req = wb_cyc_i && wb_stb_i;
    wire [wdg_pkg::ADR_W-3:0] word = wb_adr_i[wdg_pkg::ADR_W-1:2];
    wire hit_ctrl = (word == wdg_pkg::ADR_CONTROL[wdg_pkg::ADR_W-1:2]);
    wire hit_stat = (word == wdg_pkg::ADR_STATUS[wdg_pkg::ADR_W-1:2]);

    // a write lands on the edge where the master sees ack
    wire wr_fire = req && wb_we_i && ack_q;
    wire ctrl_wr = wr_fire && hit_ctrl && wb_sel_i[0];

    wire [7:0] wr_byte = wb_dat_i[7:0];
    wire wr_act = wr_byte[wdg_pkg::ACT_BIT];
    wire wr_top = wr_byte[wdg_pkg::TOP_BIT];
    wire [wdg_pkg::CNT_W-1:0] wr_cnt = wr_byte[wdg_pkg::CNT_W-1:0];
    wire [wdg_pkg::STEP_W-1:0] wr_steps = wr_byte[wdg_pkg::STEP_W-1:0];

    // option byte capture
    // taken one cycle after release, never inside the reset branch
    logic opt_valid_q;
    logic hw_q;
    logic halt_rst_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            opt_valid_q <= 1'b0;
            hw_q <= 1'b0;
            halt_rst_q <= 1'b0;
        end else if (!opt_valid_q) begin
            opt_valid_q <= 1'b1;
            hw_q <= opt_hw_watchdog;
            halt_rst_q <= opt_halt_reset;
        end
    end

    // activation and counter
    logic act_q;
    logic [wdg_pkg::CNT_W-1:0] cnt_q;
    logic [wdg_pkg::CNT_W-1:0] cnt_d;

    wire act_d = act_q || (ctrl_wr && wr_act);
    wire active = act_q || hw_q;
    wire active_d = act_d || hw_q;

    // a write wins over a tick in the same cycle
    assign cnt_d = ctrl_wr ? wr_cnt
                 : ctl.tick ? cnt_q - 1'b1
                 : cnt_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            act_q <= 1'b0;
            cnt_q <= wdg_pkg::CNT_RESET;
        end else begin
            act_q <= act_d;
            cnt_q <= cnt_d;
        end
    end

    // remaining steps before the top bit drops
    wire [wdg_pkg::STEP_W-1:0] loaded_step_count =
        cnt_q[wdg_pkg::STEP_W-1:0];

    // reset sources
    wire timeout_hit = active && ctl.tick && !ctrl_wr
        && (cnt_q == wdg_pkg::CNT_EDGE);
    wire soft_hit = ctrl_wr && active_d && !wr_top;
    wire halt_hit = halt_req && active && halt_rst_q;

    // a running pulse already resets the part; further hits are dropped
    assign ctl.fire = (timeout_hit || soft_hit || halt_hit)
        && !ctl.busy;

    wdg_pkg::cause_type cause_q;
    wdg_pkg::cause_type cause_d;

    assign cause_d = !ctl.fire ? cause_q
                   : soft_hit ? wdg_pkg::CAUSE_SOFT
                   : halt_hit ? wdg_pkg::CAUSE_HALT
                   : wdg_pkg::CAUSE_TIMEOUT;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cause_q <= wdg_pkg::CAUSE_NONE;
        end else begin
            cause_q <= cause_d;
        end
    end

    // halt is granted only when it does not turn into a reset
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            halt_enter <= 1'b0;
        end else begin
            halt_enter <= halt_req && !halt_hit;
        end
    end

    // reset pin readback, three stages for a clean level
    logic [2:0] pin_sync_q;
    logic pin_lvl_q;

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            pin_sync_q <= 3'h7;
            pin_lvl_q <= 1'b1;
        end else begin
            pin_sync_q <= {pin_sync_q[1:0], rst_pin_in};
            if (pin_sync_q[1] == pin_sync_q[2]) begin
                pin_lvl_q <= pin_sync_q[2];
            end
        end
    end

    // read mux
    wire [31:0] ctrl_word = {24'h000000, act_q, cnt_q};
    wire [31:0] stat_word = {
        18'h00000,
        loaded_step_count,
        1'b0,
        cause_q,
        pin_lvl_q,
        ctl.busy,
        halt_rst_q,
        hw_q,
        active
    };
    wire [31:0] rd_word = hit_ctrl ? ctrl_word
                        : hit_stat ? stat_word
                        : 32'h00000000;

    // one wait state; unmapped reads return zero, writes are dropped
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ack_q <= 1'b0;
            dat_q <= 32'h00000000;
        end else begin
            ack_q <= req && !ack_q;
            if (req && !ack_q) begin
                dat_q <= rd_word;
            end
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;

    // checks

    a_count_step: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (ctl.tick && !ctrl_wr)
        |=> (cnt_q == 7'($past(cnt_q) - 7'h01)))
        else $error("counter did not step down on tick");

    a_count_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (!ctl.tick && !ctrl_wr) |=> $stable(cnt_q))
        else $error("counter moved without a tick");

    a_timeout_fire: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (active && ctl.tick && !ctrl_wr && !ctl.busy
            && cnt_q == wdg_pkg::CNT_EDGE)
        |=> (ctl.busy && !rst_pin_oe_n))
        else $error("timeout did not start a reset pulse");

    a_inactive_quiet: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (!active_d && !halt_req && !ctl.busy) |=> !ctl.busy)
        else $error("reset pulse while inactive");

    a_reset_disabled: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $fell(sys_rst) |-> (!act_q && cause_q == wdg_pkg::CAUSE_NONE))
        else $error("watchdog active right after reset");

    a_act_sticky: assert property (
        @(posedge mclk) disable iff (sys_rst)
        act_q |=> act_q)
        else $error("activation bit was cleared");

    a_soft_reset: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (ctrl_wr && wr_act && !wr_top && !ctl.busy)
        |=> (ctl.busy && cause_q == wdg_pkg::CAUSE_SOFT))
        else $error("software reset not taken");

    a_halt_reset: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (halt_req && active && halt_rst_q && !ctl.busy)
        |=> (ctl.busy && !halt_enter))
        else $error("halt while active did not reset");

    a_halt_pass: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (halt_req && !halt_rst_q) |=> halt_enter)
        else $error("halt not granted with option off");

    a_option_latch: assert property (
        @(posedge mclk) disable iff (sys_rst)
        $rose(opt_valid_q)
        |-> (hw_q == $past(opt_hw_watchdog)
            && halt_rst_q == $past(opt_halt_reset)))
        else $error("option bits not captured");

    a_write_load: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ctrl_wr |=> (cnt_q == $past(wr_cnt)))
        else $error("control write did not load counter");

    a_ack_single: assert property (
        @(posedge mclk) disable iff (sys_rst)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");

    a_ack_answer: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (req && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");

    // unmapped words read as zero so software can probe safely
    a_unmapped_read: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (req && !wb_ack_o && !hit_ctrl && !hit_stat)
        |=> (wb_dat_o == 32'h00000000))
        else $error("unmapped read not zero");

    // options are frozen from capture until the next reset
    a_option_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        opt_valid_q |=> ($stable(hw_q) && $stable(halt_rst_q)))
        else $error("option bits changed after capture");

    a_hw_timeout: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (hw_q && ctl.tick && !ctrl_wr && !ctl.busy
            && cnt_q == wdg_pkg::CNT_EDGE)
        |=> ctl.busy)
        else $error("hardware watchdog did not time out");

    // pin enable and pulse state come from one next-state term
    a_pin_follows: assert property (
        @(posedge mclk) disable iff (sys_rst)
        (rst_pin_oe_n == !ctl.busy) && (rst_pin_out == 1'b0))
        else $error("reset pin out of step with pulse");

    // the recorded cause only changes when a pulse starts
    a_cause_hold: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !ctl.fire |=> $stable(cause_q))
        else $error("cause changed without a pulse");

    a_halt_idle: assert property (
        @(posedge mclk) disable iff (sys_rst)
        !halt_req |=> !halt_enter)
        else $error("halt granted without request");

    a_halt_grant: assert property (
        @(posedge mclk) disable iff (sys_rst)
        halt_enter |-> ($past(halt_req) && !$past(halt_hit)))
        else $error("halt granted instead of reset");

    a_step_load: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ctrl_wr |=> (loaded_step_count == $past(wr_steps)))
        else $error("step count not loaded");

    a_tick_single: assert property (
        @(posedge mclk) disable iff (sys_rst)
        ctl.tick |=> !ctl.tick)
        else $error("prescaler tick longer than a cycle");

endmodule
